// ### src/plc_pkg.sv
package plc_pkg;
    // Register byte offsets on the control bus
    localparam logic [4:0]  OFF_LUT_A  = 5'h00;
    localparam logic [4:0]  OFF_LUT_B  = 5'h04;
    localparam logic [4:0]  OFF_CFG    = 5'h08;
    localparam logic [4:0]  OFF_IOCFG  = 5'h0c;
    localparam logic [4:0]  OFF_STAT   = 5'h10;
    // Reset values
    localparam logic [31:0] RST_LUT    = 32'h0000_0000;
    localparam logic [31:0] RST_CFG    = 32'h0000_0000;
    localparam logic [31:0] RST_IOCFG  = 32'h0000_0000;
    // Cluster configuration field positions
    localparam int          CFG_INV_A  = 0;
    localparam int          CFG_INV_B  = 1;
    localparam int          CFG_POL    = 2;
    localparam int          CFG_SRC    = 3;
    localparam int          CFG_PAIR   = 4;
    // I/O configuration: two mode bits per cell from bit 0, used bits from bit 8
    localparam int          IO_N       = 4;
    localparam int          IOCFG_USED = 8;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {IO_IN, IO_OUT, IO_TRI, IO_BIDIR} plc_io_mode_e;

    // Inputs of the two combinational cells
    typedef struct packed {
        logic [4:0] cell_a;
        logic [4:0] cell_b;
    } plc_cell_in_s;

    // Control inputs of the register cell
    typedef struct packed {
        logic clr;
        logic pre;
        logic enable_select_low;
        logic enable_select_high;
        logic clk_hw;
        logic clk_rt;
    } plc_reg_ctl_s;
endpackage

// ### src/plc_cluster.sv
module plc_cluster
    import plc_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                resetn_in,
    // AXI4-Lite write address and data
    input  wire logic [4:0]          s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp_out,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    // AXI4-Lite read
    input  wire logic [4:0]          s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in,
    // Cluster logic
    input  wire plc_cell_in_s        cells_in,
    input  wire plc_reg_ctl_s        reg_ctl_in,
    output logic                     cell_a_out,
    output logic                     cell_b_out,
    output logic                     reg_q_out,
    // I/O cells
    input  wire logic [IO_N-1:0]     pad_in,
    output logic [IO_N-1:0]          pad_out,
    output logic [IO_N-1:0]          pad_oe_out,
    input  wire logic [IO_N-1:0]     user_out_in,
    input  wire logic [IO_N-1:0]     user_oe_in,
    output logic [IO_N-1:0]          user_pad_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Five-input table lookup with optional inversion of the top input
    function automatic logic lut5(input logic [31:0] tt, input logic [4:0] x,
                                  input logic inv);
        logic invertible_input;
        invertible_input = x[4] ^ inv;
        return tt[{invertible_input, x[3:0]}];
    endfunction

    // Merge write data under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic [31:0] lut_a_r;
    logic [31:0] lut_b_r;
    logic [31:0] cfg_r;
    logic [31:0] iocfg_r;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [4:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        do_write;
    logic        wr_hit;
    logic [31:0] status;

    assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
    assign s_axi_wready_out  = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid_out  = bvalid_r;
    assign s_axi_bresp_out   = bresp_r;
    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out  = rvalid_r;
    assign s_axi_rdata_out   = rdata_r;
    assign s_axi_rresp_out   = rresp_r;
    assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_hit   = awaddr_r == OFF_LUT_A || awaddr_r == OFF_LUT_B
                   || awaddr_r == OFF_CFG || awaddr_r == OFF_IOCFG;

    // Capture write address and data in either order
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 5'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr_in;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata_in;
                wstrb_r  <= s_axi_wstrb_in;
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_r <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lut_a_r <= RST_LUT;
            lut_b_r <= RST_LUT;
            cfg_r   <= RST_CFG;
            iocfg_r <= RST_IOCFG;
        end else if (do_write) begin
            unique case (awaddr_r)
                OFF_LUT_A: lut_a_r <= merge(lut_a_r, wdata_r, wstrb_r);
                OFF_LUT_B: lut_b_r <= merge(lut_b_r, wdata_r, wstrb_r);
                OFF_CFG:   cfg_r   <= merge(cfg_r, wdata_r, wstrb_r);
                OFF_IOCFG: iocfg_r <= merge(iocfg_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // Read channel, one cycle after the address is taken
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= RESP_OKAY;
            unique case (s_axi_araddr_in)
                OFF_LUT_A: rdata_r <= lut_a_r;
                OFF_LUT_B: rdata_r <= lut_b_r;
                OFF_CFG:   rdata_r <= cfg_r;
                OFF_IOCFG: rdata_r <= iocfg_r;
                OFF_STAT:  rdata_r <= status;
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_in) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Combinational cells and register cell, ordered as C-R-C

    logic lut_a;
    logic lut_b;
    logic sel_clk;
    logic lvl;
    logic prev_lvl_r;
    logic clk_edge;
    logic ce;
    logic q_r;
    logic master_r;
    logic slave_r;

    assign lut_a    = lut5(lut_a_r, cells_in.cell_a, cfg_r[CFG_INV_A]);
    assign lut_b    = lut5(lut_b_r, cells_in.cell_b, cfg_r[CFG_INV_B]);
    assign sel_clk  = cfg_r[CFG_SRC] ? reg_ctl_in.clk_rt : reg_ctl_in.clk_hw;
    assign lvl      = sel_clk ^ cfg_r[CFG_POL];
    assign clk_edge = lvl && !prev_lvl_r;
    assign ce = reg_ctl_in.enable_select_low && reg_ctl_in.enable_select_high;

    // Left cell feeds the register; right cell sits after it
    assign cell_a_out = lut_a;
    assign cell_b_out = cfg_r[CFG_PAIR] ? slave_r : lut_b;
    // Clear and preset override the stored bit without waiting for an edge
    assign reg_q_out  = reg_ctl_in.clr ? 1'b0 : (reg_ctl_in.pre ? 1'b1 : q_r);

    // Previous level of the selected clock for edge detection
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_lvl_r <= 1'b0;
        end else begin
            prev_lvl_r <= lvl;
        end
    end

    // Register cell storage
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_r <= 1'b0;
        end else if (reg_ctl_in.clr) begin
            q_r <= 1'b0;
        end else if (reg_ctl_in.pre) begin
            q_r <= 1'b1;
        end else if (clk_edge && ce) begin
            q_r <= lut_a;
        end
    end

    // Paired cells: master follows while clock low, slave while clock high
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            master_r <= 1'b0;
            slave_r  <= 1'b0;
        end else if (cfg_r[CFG_PAIR]) begin
            master_r <= lvl ? master_r : lut_a;
            slave_r  <= lvl ? master_r : slave_r;
        end
    end

    // Status word: cell outputs in bits 3:0, pad levels in bits 11:8
    assign status = {20'h0_0000, pad_in, 4'h0, slave_r, q_r, lut_b, lut_a};

    ////////////////////////////////////////////////////////////////////////////
    // I/O cells, purely combinational

    always_comb begin
        for (int i = 0; i < IO_N; i++) begin
            plc_io_mode_e mode;
            logic         used;
            mode = plc_io_mode_e'(iocfg_r[2*i +: 2]);
            used = iocfg_r[IOCFG_USED + i];
            pad_out[i] = user_out_in[i];
            pad_oe_out[i] = 1'b0;
            user_pad_out[i] = 1'b0;
            if (used) begin
                unique case (mode)
                    IO_IN:    user_pad_out[i] = pad_in[i];
                    IO_OUT:   pad_oe_out[i] = 1'b1;
                    IO_TRI:   pad_oe_out[i] = user_oe_in[i];
                    IO_BIDIR: begin
                        pad_oe_out[i] = user_oe_in[i];
                        user_pad_out[i] = pad_in[i];
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_clear_now;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        reg_ctl_in.clr |-> !reg_q_out ##1 (reg_ctl_in.clr || reg_ctl_in.pre || !q_r
            || clk_edge);
    endproperty
    a_clear_now: assert property (p_clear_now) else $error("clear did not force zero");
    property p_preset_now;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (reg_ctl_in.pre && !reg_ctl_in.clr) |-> reg_q_out ##1 q_r;
    endproperty
    a_preset_now: assert property (p_preset_now) else $error("preset did not force one");
    property p_both_clear;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (reg_ctl_in.pre && reg_ctl_in.clr) |=> !q_r;
    endproperty
    a_both_clear: assert property (p_both_clear) else $error("preset beat clear");
    property p_hold;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (!reg_ctl_in.clr && !reg_ctl_in.pre && !(clk_edge && ce)) |=> $stable(q_r);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without enable");
    property p_capture;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (!reg_ctl_in.clr && !reg_ctl_in.pre && clk_edge && ce) |=> q_r == $past(lut_a);
    endproperty
    a_capture: assert property (p_capture) else $error("register missed its edge");
    property p_src;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (!cfg_r[CFG_SRC] ##1 !cfg_r[CFG_SRC] && $stable(cfg_r) && $stable(reg_ctl_in.clk_hw))
            |-> !clk_edge;
    endproperty
    a_src: assert property (p_src) else $error("edge from unselected clock");
    property p_invert;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        cfg_r[CFG_INV_A] |-> cell_a_out == lut_a_r[{!cells_in.cell_a[4], cells_in.cell_a[3:0]}];
    endproperty
    a_invert: assert property (p_invert) else $error("inverted input wrong");
    property p_pair;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (cfg_r[CFG_PAIR] && !lvl ##1 cfg_r[CFG_PAIR] && lvl) |=> slave_r == $past(master_r);
    endproperty
    a_pair: assert property (p_pair) else $error("paired cells did not capture");
    property p_unused;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (pad_oe_out & ~iocfg_r[IOCFG_USED +: IO_N]) == '0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused pad driven");
    property p_bresp_hold;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (s_axi_bvalid_out && !s_axi_bready_in) |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
endmodule

// ### verif/plc_fabric_model.sv
module plc_fabric_model
    import plc_pkg::*;
(
    // Clock
    input  wire logic                clk_sys_in,
    // Pad side of the cluster
    input  wire logic [IO_N-1:0]     pad_out_in,
    input  wire logic [IO_N-1:0]     pad_oe_in,
    // Board device that may drive the pads
    input  wire logic [IO_N-1:0]     ext_val_in,
    input  wire logic [IO_N-1:0]     ext_en_in,
    output logic [IO_N-1:0]          pad_in_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [IO_N-1:0] float_r = '0;

    // Undriven pads wander so a stale value is never mistaken for data
    always_ff @(posedge clk_sys_in) begin
        float_r <= ~float_r;
    end

    // Pad level from every driver; the cluster drives while its enable is high
    assign pad_in_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_en_in & ext_val_in)
                      | (~pad_oe_in & ~ext_en_in & float_r);
endmodule

// ### verif/programmable_logic_cell_cluster_bench.sv
module programmable_logic_cell_cluster_bench;
    import plc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 0, resetn = 0;
    logic [4:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    plc_cell_in_s cells = '0;
    plc_reg_ctl_s ctl = '0;
    logic ca, cb, q;
    logic [IO_N-1:0] pad_in, pad_out, pad_oe, uout = '0, uoe = '0, upad, ext = '0, ext_en = '0;
    int err_count = 0, total_checks = 0, cyc = 0;

    plc_cluster u_plc_cluster (
        .clk_sys_in(clk), .resetn_in(resetn),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .cells_in(cells),
        .reg_ctl_in(ctl), .cell_a_out(ca), .cell_b_out(cb), .reg_q_out(q),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe), .user_out_in(uout),
        .user_oe_in(uoe), .user_pad_out(upad));

    plc_fabric_model u_plc_fabric_model (
        .clk_sys_in(clk), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
        .ext_val_in(ext), .ext_en_in(ext_en), .pad_in_out(pad_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #25 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic end_sim();
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Write: both items offered together, each released once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk("bresp", bresp, r);
        tick(1); // Idle edge: the next call never re-drives bready in this step
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk("rdata", rdata, d);
        chk("rresp", rresp, r);
        tick(1); // Idle edge: the next call never re-drives rready in this step
    endtask

    // Cluster clock level, held long enough to be seen as a level
    task automatic ck(input bit rt, input logic v);
        if (rt) ctl.clk_rt <= v;
        else ctl.clk_hw <= v;
        tick(3);
    endtask

    task automatic cl(input logic c, input logic p, input logic exp);
        ctl.clr <= c;
        ctl.pre <= p;
        tick(1);
        chk("q_ovr", q, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(16);
        resetn <= 1;
        tick(1);
        rd(OFF_LUT_A, RST_LUT, RESP_OKAY);
        rd(OFF_CFG, RST_CFG, RESP_OKAY);
        rd(OFF_IOCFG, RST_IOCFG, RESP_OKAY);
        chk("oe_rst", pad_oe, '0);
        rd(5'h14, '0, RESP_SLVERR);
        wr(5'h14, 32'hffff_ffff, RESP_SLVERR);
        // Function tables with and without the top input inverted
        wr(OFF_LUT_A, 32'h8000_0001, RESP_OKAY);
        rd(OFF_LUT_A, 32'h8000_0001, RESP_OKAY);
        wr(OFF_LUT_B, 32'h0000_0100, RESP_OKAY);
        cells <= '{cell_a: 5'h1f, cell_b: 5'h08};
        tick(1);
        chk("ca", ca, 1);
        chk("cb", cb, 1);
        cells <= '{cell_a: 5'h10, cell_b: 5'h18};
        tick(1);
        chk("ca", ca, 0);
        wr(OFF_CFG, 32'h3, RESP_OKAY);
        chk("ca_inv", ca, 1);
        chk("cb_inv", cb, 1);
        // Register: each polarity and source; the other clock must be ignored
        wr(OFF_LUT_A, 32'hffff_ffff, RESP_OKAY);
        ctl.enable_select_low <= 1;
        ctl.enable_select_high <= 1;
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CFG, 32'(c) << CFG_POL, RESP_OKAY);
            ctl.clk_hw <= c[0];
            ctl.clk_rt <= c[0];
            tick(3);
            cl(1, 0, 0);
            cl(0, 0, 0);
            ck(!c[1], !c[0]);
            chk("q_other", q, 0);
            ck(!c[1], c[0]);
            ck(c[1], !c[0]);
            chk("q_cap", q, 1);
            ck(c[1], c[0]);
        end
        // Clear, preset and their overlap
        cl(1, 0, 0);
        cl(1, 1, 0);
        cl(0, 1, 1);
        cl(0, 0, 1);
        cl(1, 0, 0);
        cl(0, 0, 0);
        // Enabled only with both select lines high
        ctl.enable_select_low <= 0;
        wr(OFF_CFG, 32'h0, RESP_OKAY);
        ck(0, 0);
        ck(0, 1);
        ck(0, 0);
        chk("q_ce0", q, 0);
        ctl.enable_select_low <= 1;
        ctl.enable_select_high <= 0;
        ck(0, 1);
        ck(0, 0);
        chk("q_ce1", q, 0);
        // Paired cells as a flip-flop: captures at the edge only
        wr(OFF_CFG, 32'h1 << CFG_PAIR, RESP_OKAY);
        ck(0, 1);
        chk("pair1", cb, 1);
        wr(OFF_LUT_A, 32'h0, RESP_OKAY);
        tick(3);
        chk("pair_hold", cb, 1);
        ck(0, 0);
        ck(0, 1);
        chk("pair0", cb, 0);
        // I/O modes on all cells at once
        uout <= 4'h3;
        uoe <= 4'h5;
        ext <= 4'ha;
        ext_en <= 4'hf;
        for (int m = 0; m < 4; m++) begin
            wr(OFF_IOCFG, 32'h0f00 | (32'(m) * 32'h55), RESP_OKAY);
            chk("oe", pad_oe, m == 0 ? 4'h0 : m == 1 ? 4'hf : 4'h5);
            chk("pout", pad_out, 4'h3);
            chk("upad", upad, m == 0 ? 4'ha : m == 3 ? 4'hb : 4'h0);
        end
        ext <= 4'h5;
        tick(1);
        chk("upad_live", upad, 4'h1);
        rd(OFF_STAT, 32'h0000_0100, RESP_OKAY);
        wr(OFF_IOCFG, 32'h0055, RESP_OKAY);
        chk("oe_unused", pad_oe, 4'h0);
        chk("upad_unused", upad, 4'h0);
        end_sim();
    end
endmodule
